// ---- logic/ssp_defs.svh ----
// constants of the serial shift port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_DATA_W      16
`define SSP_TX_DEPTH    2
`define SSP_MSB_8       4'h7
`define SSP_MSB_16      4'hF
`define SSP_CTL_W16_POS 4'hA
`define SSP_STAT_SIDL_POS 4'hD
`define SSP_PRI_DIV_0   7'h40
`define SSP_PRI_DIV_1   7'h10
`define SSP_PRI_DIV_2   7'h04
`define SSP_PRI_DIV_3   7'h01
`define SSP_SEC_BASE    4'h8
`endif

// ---- logic/ssp_pkg.sv ----
// types of the serial shift port
package ssp_pkg;
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_frame = 2'b01,
		st_shift = 2'b10,
		st_tail  = 2'b11
	} ssp_state_t;
endpackage

// ---- logic/ssp_stream_if.sv ----
// valid/ready word stream between the port and its transmit buffer
`timescale 1ns/1ps
interface ssp_stream_if #(parameter int W = 16);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ---- logic/ssp_tx_fifo.sv ----
// two-entry transmit holding buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssp_tx_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	input  wire logic   clock,
	input  wire logic   reset,
	input  wire logic   flush,
	ssp_stream_if.snk   fill,
	ssp_stream_if.src   drain
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	logic          rdy_r;
	logic          push;
	logic          pop;

	// ready is a flop so the port can show it straight
	assign push        = fill.valid && rdy_r;
	assign pop         = drain.valid && drain.ready;
	assign fill.ready  = rdy_r;
	assign drain.valid = cnt_r != '0;
	assign drain.data  = mem_r[rp_r];
	assign cnt_nxt     = flush ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	// storage needs no reset, the count guards it
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wp_r] <= fill.data;
		end
	end

	// pointers, fill level and ready
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rdy_r <= cnt_nxt < FULL;
			if (flush) begin
				wp_r <= '0;
				rp_r <= '0;
			end else begin
				if (push) begin
					wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
				end
				if (pop) begin
					rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
				end
			end
		end
	end
endmodule

// ---- logic/ssp_serial_port.sv ----
// serial shift port, master or slave, with double-buffered data paths
`timescale 1ns/1ps
`include "ssp_defs.svh"
module ssp_serial_port
	import ssp_pkg::*;
#(
	parameter int TX_DEPTH = `SSP_TX_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        port_enable,
	input  wire logic        master_mode,
	input  wire logic        word_width_select,
	input  wire logic        clock_idle_polarity,
	input  wire logic        data_change_edge,
	input  wire logic        output_disable,
	input  wire logic        framed_mode_enable,
	input  wire logic        frame_sync_direction,
	input  wire logic        slave_select_enable,
	input  wire logic        stop_in_idle,
	input  wire logic [1:0]  primary_prescale,
	input  wire logic [2:0]  secondary_prescale,
	input  wire logic        cpu_sleep,
	input  wire logic        cpu_idle,
	input  wire logic        tx_wr_valid,
	input  wire logic [15:0] tx_wr_data,
	output wire logic        tx_wr_ready,
	input  wire logic        rx_rd_strobe,
	output logic      [15:0] shared_data_buffer,
	output logic             receive_full,
	output logic             receive_overflow_flag,
	output logic             transfer_done_flag,
	input  wire logic        transfer_done_clear,
	input  wire logic        transfer_done_irq_enable,
	output logic             transfer_irq,
	input  wire logic        shift_clock_pin_in,
	output logic             shift_clock_pin_out,
	output logic             shift_clock_pin_oe_n,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_out_oe_n,
	input  wire logic        slave_select_n_in,
	output logic             slave_select_n_out,
	output logic             slave_select_n_oe_n
);
	ssp_state_t  st_r;
	logic [2:0]  sync1_r;
	logic [2:0]  sync2_r;
	logic        sck_prev_r;
	logic        w16_prev_r;
	logic        sck_r;
	logic        fr_seen_r;
	logic [3:0]  cnt_r;
	logic [15:0] sr_r;
	logic [10:0] div_r;
	logic [10:0] half_period;
	logic [15:0] sr_in;
	logic [15:0] rx_word;
	logic [3:0]  last_idx;
	logic        sck_s, sdi_s, ss_s;
	logic        width_chg, halt, gen_sync, sel_off, slave_live;
	logic        running, tick, lead, trail, chg, smp;
	logic        cmp, rx_free, ld_idle, cur_msb;

	ssp_stream_if #(.W(16)) wr_if ();
	ssp_stream_if #(.W(16)) tx_if ();

	// msb of the active word width
	function automatic logic msb_of(input logic [15:0] v, input logic w16);
		msb_of = w16 ? v[`SSP_MSB_16] : v[`SSP_MSB_8];
	endfunction

	function automatic logic [6:0] pri_div(input logic [1:0] p);
		case (p)
			2'h0:    pri_div = `SSP_PRI_DIV_0;
			2'h1:    pri_div = `SSP_PRI_DIV_1;
			2'h2:    pri_div = `SSP_PRI_DIV_2;
			default: pri_div = `SSP_PRI_DIV_3;
		endcase
	endfunction

	// software writes enter the transmit holding buffer
	assign wr_if.data  = tx_wr_data;
	assign wr_if.valid = tx_wr_valid;
	assign tx_wr_ready = wr_if.ready;

	ssp_tx_fifo #(
		.W     (16),
		.DEPTH (TX_DEPTH)
	) u_txbuf (
		.clock (clock),
		.reset (reset),
		.flush (width_chg || !port_enable),
		.fill  (wr_if),
		.drain (tx_if)
	);

	// two-stage synchronisers for clock, data and select pins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync1_r    <= 3'h7;
			sync2_r    <= 3'h7;
			sck_prev_r <= 1'b1; // matches the synchroniser reset, no false edge
			w16_prev_r <= 1'b0;
		end else begin
			sync1_r    <= {slave_select_n_in, serial_data_in, shift_clock_pin_in};
			sync2_r    <= sync1_r;
			sck_prev_r <= sync2_r[0];
			w16_prev_r <= word_width_select;
		end
	end

	assign sck_s = sync2_r[0];
	assign sdi_s = sync2_r[1];
	assign ss_s  = sync2_r[2];

	// stop conditions and select handling
	assign width_chg  = word_width_select != w16_prev_r;
	assign halt       = !port_enable || cpu_sleep || (cpu_idle && stop_in_idle) || width_chg;
	assign gen_sync   = framed_mode_enable && !frame_sync_direction;
	assign sel_off    = !master_mode && slave_select_enable && !framed_mode_enable && ss_s;
	assign slave_live = !receive_overflow_flag && !halt && !sel_off;

	// word length and shift values
	assign last_idx = word_width_select ? `SSP_MSB_16 : `SSP_MSB_8;
	assign sr_in    = {sr_r[14:0], sdi_s};
	assign rx_word  = word_width_select ? sr_in : {8'h00, sr_in[7:0]};
	assign cur_msb  = msb_of(sr_r, word_width_select);

	// master clock divider, primary times secondary factor per half period
	assign half_period = 11'(pri_div(primary_prescale))
		* 11'(`SSP_SEC_BASE - {1'b0, secondary_prescale});
	assign running = master_mode && st_r != st_idle && !receive_overflow_flag && !halt;
	assign tick    = running && div_r == half_period - 11'h001;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			div_r <= 11'h000;
		end else if (!running || tick) begin
			div_r <= 11'h000;
		end else begin
			div_r <= div_r + 11'h001;
		end
	end

	// master shift clock rests at the idle level between words
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sck_r <= 1'b0;
		end else if (!running) begin
			sck_r <= clock_idle_polarity;
		end else if (tick) begin
			sck_r <= !sck_r;
		end
	end

	// leading and trailing edges, then change and sample edges
	always_comb begin
		if (master_mode) begin
			lead  = tick && (sck_r == clock_idle_polarity);
			trail = tick && (sck_r != clock_idle_polarity);
		end else begin
			lead  = slave_live && (sck_s != sck_prev_r) && (sck_s != clock_idle_polarity);
			trail = slave_live && (sck_s != sck_prev_r) && (sck_s == clock_idle_polarity);
		end
		chg = data_change_edge ? trail : lead;
		smp = data_change_edge ? lead : trail;
	end

	// word end falls on the last sample edge, mid final bit for the master
	assign cmp     = st_r == st_shift && smp && cnt_r == last_idx && !halt && !sel_off;
	assign rx_free = !receive_full || rx_rd_strobe;
	assign ld_idle = st_r == st_idle && !halt && !sel_off && !receive_overflow_flag
		&& (master_mode ? (tx_if.valid && sck_r == clock_idle_polarity) : 1'b1);
	assign tx_if.ready = ld_idle || (cmp && !master_mode);

	// shift engine: state, bit count, shifter and data output
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_r            <= st_idle;
			cnt_r           <= 4'h0;
			sr_r            <= 16'h0000;
			fr_seen_r       <= 1'b0;
			serial_data_out <= 1'b0;
		end else if (halt || sel_off) begin
			st_r      <= st_idle;
			cnt_r     <= 4'h0;
			fr_seen_r <= 1'b0;
		end else begin
			case (st_r)
				st_idle: begin
					if (ld_idle) begin
						st_r      <= framed_mode_enable ? st_frame : st_shift;
						cnt_r     <= 4'h0;
						fr_seen_r <= 1'b0;
						if (tx_if.valid) begin
							sr_r <= tx_if.data;
						end
						if (data_change_edge) begin
							serial_data_out <= msb_of(tx_if.valid ? tx_if.data : sr_r, word_width_select);
						end
					end
				end
				st_frame: begin
					// generated pulse spans two edges, a received one is seen at sample
					if (gen_sync && (chg || smp)) begin
						fr_seen_r <= 1'b1;
						if (fr_seen_r) begin
							st_r <= st_shift;
						end
					end else if (!gen_sync && smp && ss_s) begin
						st_r <= st_shift;
					end
				end
				st_shift: begin
					if (chg) begin
						serial_data_out <= cur_msb;
					end
					if (smp) begin
						sr_r  <= sr_in;
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == last_idx) begin
							cnt_r     <= 4'h0;
							fr_seen_r <= 1'b0;
							if (master_mode) begin
								st_r <= st_tail;
							end else begin
								if (tx_if.valid) begin
									sr_r <= tx_if.data;
								end
								if (framed_mode_enable) begin
									st_r <= st_frame;
								end
							end
						end
					end
				end
				st_tail: begin
					if (sck_r == clock_idle_polarity || tick) begin
						st_r <= st_idle;
					end
				end
				default: st_r <= st_idle;
			endcase
		end
	end

	// receive buffer, full and overflow; a new event beats a read
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			shared_data_buffer    <= 16'h0000;
			receive_full          <= 1'b0;
			receive_overflow_flag <= 1'b0;
		end else begin
			if (cmp && rx_free) begin
				shared_data_buffer <= rx_word;
			end
			receive_full          <= (cmp && rx_free) || (receive_full && !rx_rd_strobe);
			receive_overflow_flag <= (cmp && !rx_free) || (receive_overflow_flag && !rx_rd_strobe);
		end
	end

	// done flag and gated interrupt; set wins over clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			transfer_done_flag <= 1'b0;
			transfer_irq       <= 1'b0;
		end else begin
			transfer_done_flag <= cmp || (transfer_done_flag && !transfer_done_clear);
			transfer_irq       <= transfer_done_flag && transfer_done_irq_enable;
		end
	end

	// pin drivers; enables are low while driving
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			shift_clock_pin_out  <= 1'b0;
			shift_clock_pin_oe_n <= 1'b1;
			serial_data_out_oe_n <= 1'b1;
			slave_select_n_out   <= 1'b0;
			slave_select_n_oe_n  <= 1'b1;
		end else begin
			shift_clock_pin_out  <= sck_r;
			shift_clock_pin_oe_n <= !master_mode;
			serial_data_out_oe_n <= output_disable || halt || sel_off;
			slave_select_n_out   <= gen_sync && st_r == st_frame;
			slave_select_n_oe_n  <= !gen_sync;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_word_end;
		cmp;
	endsequence

	sequence s_master_load;
		master_mode && ld_idle;
	endsequence

	a_done_on_end: assert property (s_word_end |=> transfer_done_flag)
		else $error("done flag not set at word end");
	a_irq_gated_off: assert property (transfer_done_flag && !transfer_done_irq_enable |=> !transfer_irq)
		else $error("interrupt raised while disabled");
	a_rx_word_moved: assert property (s_word_end ##0 rx_free
		|=> receive_full && shared_data_buffer == $past(rx_word))
		else $error("received word not moved to buffer");
	a_ovf_drops_word: assert property (s_word_end ##0 !rx_free
		|=> receive_overflow_flag && $stable(shared_data_buffer))
		else $error("overflow did not keep old word");
	a_ovf_freezes: assert property (receive_overflow_flag && !rx_rd_strobe && !halt && !sel_off
		|=> $stable(sr_r) && $stable(cnt_r))
		else $error("port moved during overflow");
	a_slave_reload: assert property (!master_mode ##0 s_word_end ##0 tx_if.valid
		|=> sr_r == $past(tx_if.data))
		else $error("shifter not reloaded from transmit buffer");
	a_master_starts: assert property (s_master_load |=> st_r != st_idle)
		else $error("master did not start on pending word");
	a_master_mid_bit: assert property (master_mode ##0 s_word_end |-> tick ##1 st_r == st_tail)
		else $error("master word end not on a clock tick");
	a_width_resets: assert property (width_chg |=> st_r == st_idle && cnt_r == 4'h0)
		else $error("width change did not reset port");
	a_msb_out: assert property (st_r == st_shift && chg && !halt && !sel_off
		|=> serial_data_out == $past(cur_msb))
		else $error("output bit not the word msb");
	a_out_disabled: assert property (output_disable |=> serial_data_out_oe_n)
		else $error("data output driven while disabled");
	a_select_release: assert property (sel_off |=> st_r == st_idle && cnt_r == 4'h0 && serial_data_out_oe_n)
		else $error("select high did not reset port");
	a_sleep_abort: assert property (cpu_sleep |=> st_r == st_idle && $stable(shared_data_buffer))
		else $error("sleep did not abort cleanly");
	a_idle_stop: assert property (cpu_idle && stop_in_idle
		|=> st_r == st_idle && serial_data_out_oe_n)
		else $error("port ran during idle with stop set");
endmodule

// ---- dv/ssp_far_end.sv ----
// far-end serial peripheral model used by the port bench
`timescale 1ns/1ps
module ssp_far_end (
	input  wire logic        sck,
	input  wire logic        pol,
	input  wire logic        width16,
	input  wire logic        mosi,
	input  wire logic        load,
	input  wire logic [15:0] load_word,
	output logic             miso,
	output logic      [15:0] got
);
	logic [15:0] sh_r;
	wire         act = sck ^ pol;
	// capture incoming data on the leading clock edge
	always @(posedge act) got = {got[14:0], mosi};
	// next bit on the trailing edge, word loaded on request
	always @(negedge act or posedge load) begin
		if (load) sh_r = load_word;
		else sh_r = sh_r << 1;
	end
	// most significant bit of the active width first
	assign miso = width16 ? sh_r[15] : sh_r[7];
endmodule

// ---- dv/ssp_serial_port_tb_top.sv ----
// self-checking bench of the serial shift port in master and slave roles
`timescale 1ns/1ps
module ssp_serial_port_tb_top;
	typedef struct {logic w16, pol, ien; logic [15:0] tx, far;} ssp_row_t;
	localparam int HALF = 4 * (8 - 6);
	logic        clock, reset, port_enable, master_mode, word_width_select, clock_idle_polarity;
	logic        data_change_edge, output_disable, framed_mode_enable, frame_sync_direction;
	logic        slave_select_enable, stop_in_idle, cpu_sleep, cpu_idle, tx_wr_valid, tx_wr_ready;
	logic        rx_rd_strobe, receive_full, receive_overflow_flag, transfer_done_flag;
	logic        transfer_done_clear, transfer_done_irq_enable, transfer_irq, shift_clock_pin_out;
	logic        shift_clock_pin_oe_n, serial_data_out, serial_data_out_oe_n, slave_select_n_out;
	logic        slave_select_n_oe_n, ss_n, load, miso, t, slv_sck;
	logic [1:0]  primary_prescale;
	logic [2:0]  secondary_prescale;
	logic [15:0] tx_wr_data, shared_data_buffer, load_word, got;
	int          n_fail, check_count, c;
	ssp_row_t    rows[4] = '{'{1'h0, 1'h0, 1'h1, 16'h00A5, 16'h003C}, '{1'h1, 1'h0, 1'h0, 16'hA55A, 16'h1234},
		'{1'h0, 1'h1, 1'h0, 16'h0081, 16'h00FE}, '{1'h1, 1'h1, 1'h1, 16'hF00F, 16'h8001}};
	// pin levels: released clock and select come from the bench as master, released data line pulled up
	wire         sck_w = shift_clock_pin_oe_n ? slv_sck : shift_clock_pin_out;
	wire         sdo_w = serial_data_out_oe_n ? 1'h1 : serial_data_out;
	wire         ssn_w = slave_select_n_oe_n ? ss_n : slave_select_n_out;

	ssp_serial_port dut (.clock, .reset, .port_enable, .master_mode, .word_width_select, .clock_idle_polarity,
		.data_change_edge, .output_disable, .framed_mode_enable, .frame_sync_direction, .slave_select_enable,
		.stop_in_idle, .primary_prescale, .secondary_prescale, .cpu_sleep, .cpu_idle, .tx_wr_valid, .tx_wr_data,
		.tx_wr_ready, .rx_rd_strobe, .shared_data_buffer, .receive_full, .receive_overflow_flag,
		.transfer_done_flag, .transfer_done_clear, .transfer_done_irq_enable, .transfer_irq,
		.shift_clock_pin_in(sck_w), .shift_clock_pin_out, .shift_clock_pin_oe_n, .serial_data_in(miso),
		.serial_data_out, .serial_data_out_oe_n, .slave_select_n_in(ssn_w), .slave_select_n_out,
		.slave_select_n_oe_n);
	ssp_far_end far (.sck(sck_w), .pol(clock_idle_polarity), .width16(word_width_select), .mosi(sdo_w),
		.load, .load_word, .miso, .got);

	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	// inputs change a fixed delay after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk16(input logic [15:0] g, e, input string what);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, g, e);
		end
	endtask
	task automatic chk1(input logic g, e, input string what);
		chk16({15'h0000, g}, {15'h0000, e}, what);
	endtask
	// bounded wait for done (sel 0) or overflow (sel 1)
	task automatic wait_for(input int sel);
		int k;
		for (k = 0; k < 3000 && (sel ? receive_overflow_flag : transfer_done_flag) !== 1'h1; k++) step(1);
		chk1(k < 3000, 1'h1, "flag wait");
	endtask
	// hold the write until an edge samples ready high
	task automatic put(input logic [15:0] d);
		int k;
		tx_wr_valid = 1'h1;
		tx_wr_data = d;
		for (k = 0; k < 3000 && tx_wr_ready !== 1'h1; k++) step(1);
		step(1);
		tx_wr_valid = 1'h0;
		step(1);
	endtask
	task automatic pulse_rd();
		rx_rd_strobe = 1'h1;
		step(1);
		rx_rd_strobe = 1'h0;
	endtask
	task automatic pulse_clr();
		transfer_done_clear = 1'h1;
		step(1);
		transfer_done_clear = 1'h0;
	endtask
	// port is stopped around every width or polarity change
	task automatic cfg(input logic w, p, ie);
		port_enable = 1'h0;
		step(1);
		word_width_select = w;
		clock_idle_polarity = p;
		transfer_done_irq_enable = ie;
		step(2);
		port_enable = 1'h1;
		step(2);
	endtask
	task automatic far_load(input logic [15:0] d);
		load_word = d;
		load = 1'h1;
		step(1);
		load = 1'h0;
	endtask
	// bench acts as master on the released clock pin, idle low
	task automatic sclk_pulses(input int n);
		repeat (n) begin
			slv_sck = 1'h1;
			step(8);
			slv_sck = 1'h0;
			step(8);
		end
	endtask
	task automatic endt(input string s);
		$display("test %s finished at %0t", s, $time);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		{reset, master_mode, data_change_edge, ss_n} = 4'hF;
		{port_enable, word_width_select, clock_idle_polarity, output_disable, framed_mode_enable} = 5'h00;
		{frame_sync_direction, slave_select_enable, stop_in_idle, cpu_sleep, cpu_idle} = 5'h00;
		{tx_wr_valid, rx_rd_strobe, transfer_done_clear, transfer_done_irq_enable, load, slv_sck} = 6'h00;
		{primary_prescale, secondary_prescale, tx_wr_data, load_word} = {2'h2, 3'h6, 32'h00000000};
		{n_fail, check_count} = 0;
		repeat (5) @(posedge clock);
		#1 reset = 1'h0;
		step(2);
		// ordinary master words from the table
		foreach (rows[i]) begin
			cfg(rows[i].w16, rows[i].pol, rows[i].ien);
			far_load(rows[i].far);
			put(rows[i].tx);
			t = shift_clock_pin_out;
			for (c = 0; c < 500 && shift_clock_pin_out === t; c++) step(1);
			t = shift_clock_pin_out;
			for (c = 0; c < 500 && shift_clock_pin_out === t; c++) step(1);
			chk16(c[15:0], HALF[15:0], "half period");
			wait_for(0);
			chk16(shared_data_buffer, rows[i].w16 ? rows[i].far : {8'h00, rows[i].far[7:0]}, "rx");
			chk1(receive_full, 1'h1, "full");
			step(2);
			chk1(transfer_irq, rows[i].ien, "irq");
			chk16(rows[i].w16 ? got : {8'h00, got[7:0]}, rows[i].w16 ? rows[i].tx : {8'h00, rows[i].tx[7:0]},
				"far rx");
			pulse_rd();
			pulse_clr();
			chk1(receive_full, 1'h0, "read frees");
			step(3 * HALF);
			endt("row");
		end
		// back-to-back words without reads, then a frozen port
		cfg(1'h0, 1'h0, 1'h0);
		far_load(16'h0011);
		put(16'h00C3);
		put(16'h003C);
		wait_for(0);
		pulse_clr();
		wait_for(1);
		chk16(shared_data_buffer, 16'h0011, "kept word");
		step(HALF + 4);
		pulse_clr();
		t = shift_clock_pin_out;
		put(16'h0099);
		put(16'h0066);
		step(100);
		chk1(tx_wr_ready, 1'h0, "buffer refuses");
		chk1(shift_clock_pin_out, t, "clock frozen");
		chk1(transfer_done_flag, 1'h0, "no word end");
		pulse_rd();
		chk1(receive_overflow_flag, 1'h0, "overflow cleared");
		wait_for(0);
		pulse_clr();
		pulse_rd();
		wait_for(0);
		pulse_rd();
		pulse_clr();
		step(3 * HALF);
		endt("overflow");
		// stop in idle holds the queued word
		cpu_idle = 1'h1;
		stop_in_idle = 1'h1;
		put(16'h0055);
		step(200);
		chk1(transfer_done_flag, 1'h0, "idle halt");
		stop_in_idle = 1'h0;
		wait_for(0);
		cpu_idle = 1'h0;
		pulse_rd();
		pulse_clr();
		step(3 * HALF);
		endt("idle");
		// sleep mid-word aborts the transfer and parks the clock
		put(16'h00AA);
		step(4 * HALF);
		cpu_sleep = 1'h1;
		step(3);
		t = shift_clock_pin_out;
		step(40);
		chk1(shift_clock_pin_out, t, "sleep clock parked");
		chk1(t, 1'h0, "sleep clock idle");
		chk1(transfer_done_flag, 1'h0, "sleep aborts");
		cpu_sleep = 1'h0;
		step(3 * HALF);
		chk1(transfer_done_flag, 1'h0, "no resume after sleep");
		endt("sleep");
		output_disable = 1'h1;
		step(3);
		chk1(serial_data_out_oe_n, 1'h1, "data released");
		output_disable = 1'h0;
		step(3);
		chk1(serial_data_out_oe_n, 1'h0, "data driven");
		endt("output disable");
		// slave with select: output follows the select pin
		master_mode = 1'h0;
		slave_select_enable = 1'h1;
		step(6);
		chk1(shift_clock_pin_oe_n, 1'h1, "slave clock input");
		chk1(serial_data_out_oe_n, 1'h1, "deselected");
		ss_n = 1'h0;
		step(6);
		chk1(serial_data_out_oe_n, 1'h0, "selected");
		endt("slave select");
		// slave word on bench clock pulses, then a word cut by select high
		ss_n = 1'h1;
		step(6);
		put(16'h00B4);
		far_load(16'h00D2);
		ss_n = 1'h0;
		step(6);
		sclk_pulses(8);
		wait_for(0);
		chk16(shared_data_buffer, 16'h00D2, "slave rx");
		chk16({8'h00, got[7:0]}, 16'h00B4, "slave tx");
		pulse_rd();
		pulse_clr();
		far_load(16'h0096);
		sclk_pulses(3);
		ss_n = 1'h1;
		step(6);
		chk1(serial_data_out_oe_n, 1'h1, "cut word released");
		ss_n = 1'h0;
		step(6);
		far_load(16'h0096);
		sclk_pulses(8);
		wait_for(0);
		chk16(shared_data_buffer, 16'h0096, "restart at msb");
		pulse_rd();
		pulse_clr();
		endt("slave word");
		framed_mode_enable = 1'h1;
		step(3);
		chk1(slave_select_n_oe_n, 1'h0, "sync pin driven");
		framed_mode_enable = 1'h0;
		step(3);
		endt("framed");
		reset = 1'h1;
		step(2);
		chk1(tx_wr_ready, 1'h0, "ready in reset");
		chk1(serial_data_out_oe_n, 1'h1, "released in reset");
		reset = 1'h0;
		step(2);
		chk1(tx_wr_ready, 1'h1, "ready after reset");
		endt("reset");
		print_verdict();
	end
endmodule
